// [rtl/status_lamp_pkg.sv]
// Constants and types for the status output and lamp block
package status_lamp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int SIG_SHOW_S = 30;
  localparam int SIG_SHOW_CYC = SIG_SHOW_S * CLK_HZ;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
  localparam logic [31:0] ONE32 = 32'h0000_0001;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [3:0] ADDR_IRQ = 4'h2;
  localparam logic [3:0] ADDR_MASK = 4'h3;
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_LAMP_BIT = 4;
  localparam int CFG_PARAM_BIT = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam int NUM_EVT = 4;
  typedef enum logic [2:0] {
    FUNC_ACK = 3'h0,
    FUNC_SWITCH = 3'h1,
    FUNC_MUTE = 3'h2,
    FUNC_DIRT = 3'h3,
    FUNC_SYNC = 3'h4,
    FUNC_READY = 3'h5,
    FUNC_OFF = 3'h6
  } sig_func_t;
  typedef enum logic [1:0] {
    LAMP_OFF = 2'h0,
    LAMP_WHITE = 2'h1,
    LAMP_GREEN = 2'h2,
    LAMP_RED = 2'h3
  } lamp_color_t;
  typedef enum logic [1:0] {
    SHOW_BOOT = 2'h0,
    SHOW_HOLD = 2'h1,
    SHOW_DONE = 2'h2
  } show_state_t;
endpackage : status_lamp_pkg

// [rtl/flash_timer.sv]
// Free-running blink generator for the lamp
`timescale 1ns/1ns
module flash_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Blink phase
  output logic blinkOn_ff
);
  import status_lamp_pkg::*;
  logic [31:0] cnt_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= ZERO32;
      blinkOn_ff <= 1'b0;
    end else if (cnt_ff == 32'(FLASH_HALF_CYC - 1)) begin
      cnt_ff <= ZERO32;
      blinkOn_ff <= ~blinkOn_ff;
    end else begin
      cnt_ff <= cnt_ff + ONE32;
    end
  end
endmodule : flash_timer

// [rtl/status_output_lamp.sv]
// Signal output select, end-cap lamp and signal strength display timing
// Notes on behaviour
// - The signal output is driven only while serial link is idle.
// - Configuration picks exactly one function for the signal output.
// - Default function raises output while acknowledgment is pending.
// - Contamination function raises output on dirt or weak signal.
// - Synchronous-run function follows receiver synchronous run.
// - Ready function follows protective device ready for operation.
// - The lamp is unmonitored and never feeds back into switching.
// - A setting hides switching state on the lamp, leaving muting and override only.
// - Muting indication on the lamp can never be disabled.
// - Muting-only lamp: white steady, white flashing override, else off.
// - Combined lamp: white mute, flashing override, green on, red off.
// - After power-on signal strength shows for 30 s, then stops.
// - During parameter configuration the display may stay without limit.
`timescale 1ns/1ns
module status_output_lamp #(
  parameter int SHOW_CYC = status_lamp_pkg::SIG_SHOW_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata_ff,
  // Device status pins
  input wire logic ackPending,
  input wire logic switchOutOn,
  input wire logic mutingActive,
  input wire logic overrideActive,
  input wire logic dirtWarn,
  input wire logic syncRun,
  input wire logic devReady,
  input wire logic linkActive,
  // Signal output pin
  output logic sigOut_ff,
  output logic sigOutEn_ff,
  // Lamp and display
  output status_lamp_pkg::lamp_color_t lampColor_ff,
  output logic strengthShow_ff,
  // Interrupt
  output logic irq_ff
);
  import status_lamp_pkg::*;

  logic [NUM_EVT-1:0] pinMeta_ff;
  logic [NUM_EVT-1:0] pinSync_ff;
  logic [NUM_EVT-1:0] pinPrev_ff;
  logic [5:0] stsMeta_ff;
  logic [5:0] stsSync_ff;
  logic [5:0] cfg_ff;
  logic [NUM_EVT-1:0] irqSts_ff;
  logic [NUM_EVT-1:0] irqMask_ff;
  logic [NUM_EVT-1:0] evtPulse;
  logic [31:0] showCnt_ff;
  show_state_t showState_ff;
  logic blinkOn;
  logic nxt_sigOut;
  lamp_color_t nxt_lamp;
  sig_func_t func;
  logic ackS, swS, muteS, ovrS, dirtS, syncS, readyS, linkS;

  // Two-stage synchronisers on every pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
      stsMeta_ff <= '0;
      stsSync_ff <= '0;
    end else begin
      pinMeta_ff <= {linkActive, overrideActive, mutingActive, switchOutOn};
      pinSync_ff <= pinMeta_ff;
      stsMeta_ff <= {ackPending, dirtWarn, syncRun, devReady, 2'h0};
      stsSync_ff <= stsMeta_ff;
    end
  end

  assign swS = pinSync_ff[0];
  assign muteS = pinSync_ff[1];
  assign ovrS = pinSync_ff[2];
  assign linkS = pinSync_ff[3];
  assign readyS = stsSync_ff[2];
  assign syncS = stsSync_ff[3];
  assign dirtS = stsSync_ff[4];
  assign ackS = stsSync_ff[5];

  // Configuration register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= CFG_RESET;
    end else if (regWr && regAddr == ADDR_CFG) begin
      cfg_ff <= regWdata[5:0];
    end
  end

  // Unknown codes fall back to off, so one function is always in force
  always_comb begin
    func = sig_func_t'(cfg_ff[CFG_FUNC_LSB +: 3]);
    if (cfg_ff[CFG_FUNC_LSB +: 3] > FUNC_OFF) begin
      func = FUNC_OFF;
    end
  end

  // Signal output function select
  always_comb begin
    case (func)
      FUNC_ACK: nxt_sigOut = ackS;
      FUNC_SWITCH: nxt_sigOut = swS;
      FUNC_MUTE: nxt_sigOut = muteS;
      FUNC_DIRT: nxt_sigOut = dirtS;
      FUNC_SYNC: nxt_sigOut = syncS;
      FUNC_READY: nxt_sigOut = readyS;
      FUNC_OFF: nxt_sigOut = 1'b0;
      default: nxt_sigOut = 1'b0;
    endcase
  end

  // Pin released to the serial transceiver while the link talks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sigOut_ff <= 1'b0;
      sigOutEn_ff <= 1'b0;
    end else begin
      sigOutEn_ff <= ~linkS;
      sigOut_ff <= linkS ? 1'b0 : nxt_sigOut;
    end
  end

  flash_timer u_flash (
    .mclk(mclk),
    .rst_n(rst_n),
    .blinkOn_ff(blinkOn)
  );

  // Lamp drive is output only; switching never reads it, only the status register
  always_comb begin
    if (ovrS) begin
      nxt_lamp = blinkOn ? LAMP_WHITE : LAMP_OFF;
    end else if (muteS) begin
      nxt_lamp = LAMP_WHITE;
    end else if (cfg_ff[CFG_LAMP_BIT]) begin
      nxt_lamp = LAMP_OFF;
    end else begin
      nxt_lamp = swS ? LAMP_GREEN : LAMP_RED;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lampColor_ff <= LAMP_OFF;
    end else begin
      lampColor_ff <= nxt_lamp;
    end
  end

  // Signal strength display after power-on
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      showState_ff <= SHOW_BOOT;
      showCnt_ff <= ZERO32;
      strengthShow_ff <= 1'b0;
    end else begin
      case (showState_ff)
        SHOW_BOOT: begin
          showCnt_ff <= ZERO32;
          strengthShow_ff <= 1'b1;
          showState_ff <= SHOW_HOLD;
        end
        SHOW_HOLD: begin
          if (showCnt_ff >= 32'(SHOW_CYC - 1)) begin
            if (!cfg_ff[CFG_PARAM_BIT]) begin
              strengthShow_ff <= 1'b0;
              showState_ff <= SHOW_DONE;
            end
          end else begin
            showCnt_ff <= showCnt_ff + ONE32;
          end
        end
        SHOW_DONE: begin
          strengthShow_ff <= cfg_ff[CFG_PARAM_BIT];
        end
        default: begin
          showState_ff <= SHOW_DONE;
          strengthShow_ff <= 1'b0;
        end
      endcase
    end
  end

  // Rising edges of switching, muting, override and link pins raise sticky bits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      assign evtPulse[gi] = pinSync_ff[gi] & ~pinPrev_ff[gi];
    end
  endgenerate

  // Set beats the read clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pinPrev_ff <= '0;
      irqSts_ff <= '0;
    end else begin
      pinPrev_ff <= pinSync_ff;
      if (regRd && regAddr == ADDR_IRQ) begin
        irqSts_ff <= evtPulse;
      end else begin
        irqSts_ff <= irqSts_ff | evtPulse;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqMask_ff <= '0;
    end else if (regWr && regAddr == ADDR_MASK) begin
      irqMask_ff <= regWdata[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irqSts_ff & irqMask_ff);
    end
  end

  // Read data; unmapped addresses read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_ff <= ZERO32;
    end else if (regRd) begin
      case (regAddr)
        ADDR_CFG: regRdata_ff <= {26'h0, cfg_ff};
        ADDR_STAT: regRdata_ff <= {20'h0, strengthShow_ff, lampColor_ff,
          sigOut_ff, stsSync_ff[5:2], pinSync_ff};
        ADDR_IRQ: regRdata_ff <= {28'h0, irqSts_ff};
        ADDR_MASK: regRdata_ff <= {28'h0, irqMask_ff};
        default: regRdata_ff <= ZERO32;
      endcase
    end else begin
      regRdata_ff <= ZERO32;
    end
  end

  // Checks wait one edge after reset so held reset values never count
  logic chkArmed_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chkArmed_ff <= 1'b0;
    end else begin
      chkArmed_ff <= 1'b1;
    end
  end

  chk_link_release: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    $past(linkS) |-> !sigOutEn_ff && !sigOut_ff)
    else $error("signal output driven during link activity");
  chk_link_idle: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    !linkS |=> sigOutEn_ff)
    else $error("signal output not driven while link idle");
  chk_func_fallback: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    cfg_ff[CFG_FUNC_LSB +: 3] > FUNC_OFF |=> !sigOut_ff)
    else $error("unknown function code drove output");
  chk_ack_follow: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (func == FUNC_ACK && !linkS) |=> sigOut_ff == $past(ackS))
    else $error("ack output mismatch");
  chk_dirt_follow: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (func == FUNC_DIRT && !linkS) |=> sigOut_ff == $past(dirtS))
    else $error("contamination output mismatch");
  chk_sync_follow: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (func == FUNC_SYNC && !linkS) |=> sigOut_ff == $past(syncS))
    else $error("sync output mismatch");
  chk_ready_follow: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (func == FUNC_READY && !linkS) |=> sigOut_ff == $past(readyS))
    else $error("ready output mismatch");
  chk_switch_follow: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (func == FUNC_SWITCH && !linkS) |=> sigOut_ff == $past(swS))
    else $error("switching state output mismatch");
  chk_mute_follow: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (func == FUNC_MUTE && !linkS) |=> sigOut_ff == $past(muteS))
    else $error("muting output mismatch");
  chk_off_low: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    func == FUNC_OFF |=> !sigOut_ff)
    else $error("off function drove output");
  chk_mute_white: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (muteS && !ovrS) |=> lampColor_ff == LAMP_WHITE)
    else $error("muting not shown white");
  chk_hide_no_colour: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    cfg_ff[CFG_LAMP_BIT] |=>
    lampColor_ff != LAMP_GREEN && lampColor_ff != LAMP_RED)
    else $error("switching state shown in muting-only setting");
  chk_hide_switch: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (cfg_ff[CFG_LAMP_BIT] && !muteS && !ovrS) |=> lampColor_ff == LAMP_OFF)
    else $error("lamp not off in muting-only setting");
  chk_override_blink: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    ovrS |=> lampColor_ff == ($past(blinkOn) ? LAMP_WHITE : LAMP_OFF))
    else $error("override not shown as flashing white");
  chk_green_red: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (!cfg_ff[CFG_LAMP_BIT] && !muteS && !ovrS) |=>
    lampColor_ff == ($past(swS) ? LAMP_GREEN : LAMP_RED))
    else $error("combined lamp colour wrong");
  chk_show_boot: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    showState_ff == SHOW_BOOT |=>
    strengthShow_ff && showState_ff == SHOW_HOLD)
    else $error("strength display not started after power-on");
  chk_show_count: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (showState_ff == SHOW_HOLD && showCnt_ff < 32'(SHOW_CYC - 1)) |=>
    strengthShow_ff)
    else $error("strength display ended early");
  chk_show_end: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (showState_ff == SHOW_DONE && !cfg_ff[CFG_PARAM_BIT]) |=>
    !strengthShow_ff)
    else $error("strength display outlived its time");
  chk_show_done: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    showState_ff == SHOW_DONE |=> showState_ff == SHOW_DONE)
    else $error("power-on display restarted");
  chk_show_param: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (showState_ff != SHOW_BOOT && cfg_ff[CFG_PARAM_BIT]) |=>
    strengthShow_ff)
    else $error("strength display dropped during configuration");
  chk_param_hold: assert property (@(posedge mclk)
    disable iff (!rst_n || !chkArmed_ff)
    (showState_ff == SHOW_HOLD && cfg_ff[CFG_PARAM_BIT]) |=>
    showState_ff == SHOW_HOLD)
    else $error("power-on display timed out during configuration");
endmodule : status_output_lamp

// [verif/machine_input_model.sv]
// Machine control input that reads the signal output pin
`timescale 1ns/1ns
module machine_input_model (
  // Pin as driven by the device
  input wire logic sigOut,
  input wire logic sigOutEn,
  // Level seen by the control input
  output logic pinLevel
);
  // Input pull-down: an undriven pin reads low, never the last value
  assign pinLevel = sigOutEn ? sigOut : 1'b0;
endmodule : machine_input_model

// [verif/status_output_lamp_bench.sv]
// Self-checking bench for the status output and lamp block
`timescale 1ns/1ns
module status_output_lamp_bench;
  import status_lamp_pkg::*;
  localparam int SHOW = 20;
  logic mclk, rst_n, regWr, regRd, pinLevel;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata_ff;
  logic [7:0] pins;
  logic sigOut_ff, sigOutEn_ff, strengthShow_ff, irq_ff, irqA;
  lamp_color_t lampColor_ff;
  int nMismatch = 0;
  int checkCount = 0;
  int srcIdx [6] = '{0, 1, 2, 4, 5, 6};
  logic [7:0] lCfg [7] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h10, 8'h10, 8'h20};
  logic [7:0] lPin [7] = '{8'h02, 8'h00, 8'h06, 8'h02, 8'h06, 8'h00, 8'h02};
  logic [1:0] lExp [7] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2};

  status_output_lamp #(.SHOW_CYC(SHOW)) uut (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata_ff(regRdata_ff),
    .ackPending(pins[0]), .switchOutOn(pins[1]), .mutingActive(pins[2]),
    .overrideActive(pins[3]), .dirtWarn(pins[4]), .syncRun(pins[5]),
    .devReady(pins[6]), .linkActive(pins[7]), .sigOut_ff(sigOut_ff),
    .sigOutEn_ff(sigOutEn_ff), .lampColor_ff(lampColor_ff),
    .strengthShow_ff(strengthShow_ff), .irq_ff(irq_ff)
  );
  machine_input_model plc (
    .sigOut(sigOut_ff), .sigOutEn(sigOutEn_ff), .pinLevel(pinLevel)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    // Read data stand only until the next edge
    #1 d = regRdata_ff;
  endtask : rd

  // Pin changes need two sync stages plus the output register
  task automatic setPins(logic [7:0] v);
    @(posedge mclk);
    pins <= v;
    repeat (4) @(posedge mclk);
    #1;
  endtask : setPins

  task automatic reportAndStop;
    $display("Checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : reportAndStop

  initial begin
    #5000000;
    nMismatch++;
    reportAndStop();
  end

  initial begin
    logic [31:0] d;
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 4'h0;
    regWdata = 32'h0000_0000;
    pins = 8'h00;
    repeat (10) @(posedge mclk);
    chk("enable in reset", sigOutEn_ff, 0);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk("show after power-on", strengthShow_ff, 1);
    repeat (SHOW - 2) @(posedge mclk);
    #1 chk("show at last cycle", strengthShow_ff, 1);
    @(posedge mclk);
    #1 chk("show ended", strengthShow_ff, 0);
    rd(ADDR_CFG, d);
    chk("cfg default", d, 32'h0000_0000);
    for (int f = 0; f < 6; f++) begin
      wr(ADDR_CFG, f);
      setPins(8'h01 << srcIdx[f]);
      chk("source high", pinLevel, 1);
      setPins(8'h7F & ~(8'h01 << srcIdx[f]));
      chk("source low", pinLevel, 0);
    end
    for (int f = 6; f < 8; f++) begin
      wr(ADDR_CFG, f);
      setPins(8'h7F);
      chk("function off", sigOut_ff, 0);
    end
    wr(ADDR_CFG, 32'h0000_0000);
    setPins(8'h81);
    chk("link enable", sigOutEn_ff, 0);
    chk("link level", pinLevel, 0);
    setPins(8'h01);
    chk("idle link enable", sigOutEn_ff, 1);
    chk("idle link level", pinLevel, 1);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_CFG, lCfg[i]);
      setPins(lPin[i]);
      chk("lamp colour", lampColor_ff, lExp[i]);
    end
    wr(ADDR_CFG, 32'h0000_0010);
    setPins(8'h0E);
    chk("override blink", (lampColor_ff == LAMP_WHITE) ||
        (lampColor_ff == LAMP_OFF), 1);
    // Unlimited display while configuration is under way
    wr(ADDR_CFG, 32'h0000_0020);
    repeat (3 * SHOW) @(posedge mclk);
    #1 chk("show held", strengthShow_ff, 1);
    rd(ADDR_CFG, d);
    chk("cfg readback", d, 32'h0000_0020);
    rd(4'hF, d);
    chk("unmapped read", d, 32'h0000_0000);
    setPins(8'h00);
    rd(ADDR_IRQ, d);
    wr(ADDR_MASK, 32'h0000_000F);
    setPins(8'h04);
    irqA = irq_ff;
    chk("irq raised", irqA, 1);
    rd(ADDR_STAT, d);
    chk("status word", d, 32'h0000_0A02);
    rd(ADDR_IRQ, d);
    chk("irq mute event", d, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    #1 chk("irq low after read", irq_ff, 0);
    rd(ADDR_IRQ, d);
    chk("irq cleared", d, 32'h0000_0000);
    wr(ADDR_MASK, 32'h0000_0000);
    setPins(8'h0C);
    chk("masked irq", irq_ff, 0);
    rd(ADDR_IRQ, d);
    chk("masked event kept", d, 32'h0000_0004);
    // Second power-on with configuration under way keeps the display
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wr(ADDR_CFG, 32'h0000_0020);
    repeat (SHOW + 4) @(posedge mclk);
    #1 chk("show kept in config", strengthShow_ff, 1);
    wr(ADDR_CFG, 32'h0000_0000);
    @(posedge mclk);
    #1 chk("show ends after config", strengthShow_ff, 0);
    reportAndStop();
  end
endmodule : status_output_lamp_bench
